// >>> design/abs_position_serial_readout.sv
// Purpose: serial readout of absolute position over shared terminals
// Assumes: pins are asynchronous; sample source runs on clock
// Notes:   one 64-bit frame per enable, check word computed on load
`timescale 1ns/100ps

`include "abs_readout_defines.svh"

module sample_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
        logic                        not_full;
    } fifo_state_t;

    fifo_state_t state_reg;
    fifo_state_t state_next;
    logic        push;
    logic        pop;

    assign in_ready  = state_reg.not_full;
    assign out_valid = state_reg.count != '0;
    assign out_data  = state_reg.mem[state_reg.rd_ptr];
    assign push      = in_valid && state_reg.not_full;
    assign pop       = out_ready && out_valid;

    always_comb begin
        state_next = state_reg;
        if (push) begin
            state_next.mem[state_reg.wr_ptr] = in_data;
            state_next.wr_ptr = (state_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : state_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            state_next.rd_ptr = (state_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : state_reg.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            state_next.count = state_reg.count + 1'b1;
        end else if (pop && !push) begin
            state_next.count = state_reg.count - 1'b1;
        end
        state_next.not_full = state_next.count != (AW + 1)'(DEPTH);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg          <= '0;
            state_reg.not_full <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

module abs_position_serial_readout #(
    parameter int TAKEOVER_CYCLES      = `TAKEOVER_CYCLES,
    parameter int PREPARE_CYCLES       = `PREPARE_CYCLES,
    parameter int WARNING_CLEAR_CYCLES = `WARNING_CLEAR_CYCLES
) (
    input  wire logic                              clock,
    input  wire logic                              rst_n,
    input  wire logic                              position_read_enable,
    input  wire logic                              shared_input_terminal,
    output logic                                   shared_output_terminal,
    input  wire logic                              normal_output_function,
    output logic                                   held_input_function,
    output logic                                   takeover_active,
    input  wire abs_readout_pkg::position_sample_t sample_data,
    input  wire logic                              sample_valid,
    output logic                                   sample_ready,
    input  wire logic                              battery_low,
    input  wire logic                              battery_warning_select,
    output logic                                   battery_fault,
    output logic                                   battery_warning
);
    import abs_readout_pkg::*;

    // unsigned 16-bit arithmetic; sums wrap, carries dropped
    function automatic logic [15:0] check_word(input logic [15:0] turns, input logic [31:0] pulses);
        logic [15:0] acc;
        acc = 16'(pulses[15:0] + `CHECK_ADD_0);
        acc = acc ^ pulses[31:16];
        acc = 16'(acc + `CHECK_ADD_1);
        acc = acc ^ turns;
        acc = 16'(acc + `CHECK_ADD_2);
        return acc;
    endfunction

    typedef struct packed {
        logic [2:0]     sync_enable;  // [0] first stage, [1] second, [2] history
        logic [2:0]     sync_request;
        logic [1:0]     sync_battery;
        readout_state_t phase;
        logic [31:0]    timer;
        logic [63:0]    frame;
        logic [5:0]     bit_index;
        logic           held_level;
        logic           takeover;
        logic           data_bit;
        logic           out_pin;
        logic           fault;
        logic           warning;
        logic [31:0]    restore_timer;
    } readout_regs_t;

    readout_regs_t    state_reg;
    readout_regs_t    state_next;
    position_sample_t fifo_data;
    logic             fifo_valid;
    logic             fifo_pop;
    logic             enable_level;
    logic             request_level;
    logic             request_fell;
    logic             battery_level;

    sample_fifo #(
        .WIDTH ($bits(position_sample_t)),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_data   (sample_data),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    assign enable_level  = state_reg.sync_enable[1];
    assign request_level = state_reg.sync_request[1];
    assign request_fell  = state_reg.sync_request[2] && !state_reg.sync_request[1];
    assign battery_level = state_reg.sync_battery[1];
    // a sample is consumed only when the takeover completes
    assign fifo_pop      = state_reg.phase == ST_SETTLE && enable_level && fifo_valid
                           && state_reg.timer >= 32'(TAKEOVER_CYCLES - 1);

    assign shared_output_terminal = state_reg.out_pin;
    assign held_input_function    = state_reg.held_level;
    assign takeover_active        = state_reg.takeover;
    assign battery_fault          = state_reg.fault;
    assign battery_warning        = state_reg.warning;

    always_comb begin
        state_next = state_reg;
        state_next.sync_enable  = {state_reg.sync_enable[1:0], position_read_enable};
        state_next.sync_request = {state_reg.sync_request[1:0], shared_input_terminal};
        state_next.sync_battery = {state_reg.sync_battery[0], battery_low};

        case (state_reg.phase)
            ST_IDLE: begin
                state_next.timer = '0;
                if (enable_level) begin
                    state_next.phase = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (!state_reg.timer[31]) begin
                    state_next.timer = state_reg.timer + 32'h0000_0001;
                end
                if (fifo_pop) begin
                    state_next.takeover   = 1'b1;
                    state_next.held_level = request_level;
                    state_next.frame      = {check_word(fifo_data.turn_count, fifo_data.pulse_count),
                                             fifo_data.turn_count, fifo_data.pulse_count};
                    state_next.bit_index  = '0;
                    state_next.phase      = ST_WAIT_REQ_LOW;
                end
            end
            ST_WAIT_REQ_LOW: begin
                state_next.timer = '0;
                if (request_fell) begin
                    state_next.phase = ST_PREPARE;
                end
            end
            ST_PREPARE: begin
                state_next.timer = state_reg.timer + 32'h0000_0001;
                if (state_reg.timer >= 32'(PREPARE_CYCLES - 1)) begin
                    state_next.data_bit = state_reg.frame[state_reg.bit_index];
                    state_next.phase    = ST_SHOW;
                end
            end
            ST_SHOW: begin
                // host raises request once it has sampled the bit
                if (request_level) begin
                    state_next.bit_index = state_reg.bit_index + 6'h01;
                    state_next.phase     = (state_reg.bit_index == 6'(`FRAME_BITS - 1)) ? ST_DONE
                                                                                       : ST_WAIT_REQ_LOW;
                end
            end
            ST_DONE: begin
                state_next.phase = ST_DONE;
            end
            default: begin
                state_next.phase = ST_IDLE;
            end
        endcase

        // dropping enable ends any transfer; a new one starts from idle
        if (!enable_level && state_reg.phase != ST_IDLE) begin
            state_next.phase    = ST_IDLE;
            state_next.takeover = 1'b0;
            state_next.data_bit = 1'b0;
            state_next.timer    = '0;
        end

        // old input function sees the live pin unless frozen by takeover
        if (!state_next.takeover) begin
            state_next.held_level = request_level;
        end
        state_next.out_pin = state_next.takeover ? state_next.data_bit : normal_output_function;

        if (battery_level) begin
            state_next.restore_timer = '0;
            if (battery_warning_select == `BATTERY_SELECT_WARN) begin
                state_next.warning = 1'b1;
            end else begin
                state_next.fault = 1'b1;
            end
        end else if (state_reg.warning) begin
            state_next.restore_timer = state_reg.restore_timer + 32'h0000_0001;
            if (state_reg.restore_timer >= 32'(WARNING_CLEAR_CYCLES - 1)) begin
                state_next.warning       = 1'b0;
                state_next.restore_timer = '0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg       <= '0;
            state_reg.phase <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

// >>> design/abs_readout_defines.svh
// Purpose: timing counts and fixed constants of the position readout
// Assumes: 100 MHz clock, times in ns; warning time in us so no count exceeds 32 bits
// Notes:   cycle counts derive from the times and the clock period
`ifndef ABS_READOUT_DEFINES_SVH
`define ABS_READOUT_DEFINES_SVH

`define CLOCK_PERIOD_NS       10
`define TAKEOVER_DELAY_NS     2000000
`define DATA_PREPARE_DELAY_NS 62500
`define WARNING_CLEAR_US      5000000
`define TAKEOVER_CYCLES       ((`TAKEOVER_DELAY_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define PREPARE_CYCLES        ((`DATA_PREPARE_DELAY_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define WARNING_CLEAR_CYCLES  (`WARNING_CLEAR_US * (1000 / `CLOCK_PERIOD_NS))
`define CHECK_ADD_0           16'ha700
`define CHECK_ADD_1           16'h605a
`define CHECK_ADD_2           16'h5a06
`define FRAME_BITS            64
`define FIFO_DEPTH            8
`define BATTERY_SELECT_FAULT  1'b0
`define BATTERY_SELECT_WARN   1'b1

`endif

// >>> design/abs_readout_pkg.sv
// Purpose: shared types of the position readout
// Assumes: nothing beyond the defines header
// Notes:   sample word carries turn count and single-turn pulses
package abs_readout_pkg;

    typedef struct packed {
        logic [15:0] turn_count;
        logic [31:0] pulse_count;
    } position_sample_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETTLE,
        ST_WAIT_REQ_LOW,
        ST_PREPARE,
        ST_SHOW,
        ST_DONE
    } readout_state_t;

endpackage

// >>> dv/abs_readout_properties.sv
// Purpose: port-level properties of the position readout
// Assumes: shortened timing counts handed on by the bind
// Notes:   counters watch raw pins; sync lag only adds margin
`timescale 1ns/100ps
module abs_readout_properties #(
    parameter int TAKEOVER_CYCLES      = 20,
    parameter int PREPARE_CYCLES       = 5,
    parameter int WARNING_CLEAR_CYCLES = 50
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic position_read_enable,
    input wire logic shared_input_terminal,
    input wire logic shared_output_terminal,
    input wire logic normal_output_function,
    input wire logic held_input_function,
    input wire logic takeover_active,
    input wire logic battery_low,
    input wire logic battery_warning_select,
    input wire logic battery_fault,
    input wire logic battery_warning
);
    int en_cnt;
    int req_cnt;
    int ok_cnt;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_cnt  <= 0;
            req_cnt <= 0;
            ok_cnt  <= 0;
        end else begin
            en_cnt  <= position_read_enable ? en_cnt + 1 : 0;
            req_cnt <= shared_input_terminal ? 0 : req_cnt + 1;
            ok_cnt  <= battery_low ? 0 : ok_cnt + 1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_takeover_delay; $rose(takeover_active) |-> en_cnt >= TAKEOVER_CYCLES; endproperty
    property p_abort; !position_read_enable [*6] |-> !takeover_active; endproperty
    property p_prepare;
        takeover_active && $past(takeover_active) && $changed(shared_output_terminal) |-> req_cnt >= PREPARE_CYCLES;
    endproperty
    property p_held; takeover_active && $past(takeover_active) |-> $stable(held_input_function); endproperty
    property p_idle_out;
        $past(rst_n) && !takeover_active && !$past(takeover_active)
            |-> shared_output_terminal == $past(normal_output_function);
    endproperty
    property p_fault_sticky; battery_fault |=> battery_fault; endproperty
    property p_fault_sel; $rose(battery_fault) |-> !$past(battery_warning_select); endproperty
    property p_warn_sel; $rose(battery_warning) |-> $past(battery_warning_select); endproperty
    property p_warn_clear; $fell(battery_warning) |-> ok_cnt >= WARNING_CLEAR_CYCLES; endproperty
    a_takeover_delay: assert property (p_takeover_delay) else $error("takeover before enable settled");
    a_abort: assert property (p_abort) else $error("takeover outlives enable");
    a_prepare: assert property (p_prepare) else $error("data bit too early");
    a_held: assert property (p_held) else $error("held input moved in takeover");
    a_idle_out: assert property (p_idle_out) else $error("idle output not normal function");
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault cleared");
    a_fault_sel: assert property (p_fault_sel) else $error("fault in warning mode");
    a_warn_sel: assert property (p_warn_sel) else $error("warning in fault mode");
    a_warn_clear: assert property (p_warn_clear) else $error("warning cleared early");
    c_takeover: cover property ($rose(takeover_active));
    c_fault: cover property ($rose(battery_fault));
    c_warn_clear: cover property ($fell(battery_warning));
endmodule

// >>> dv/host_readout_model.sv
// Purpose: host controller reading the position frame
// Assumes: waits scaled down with the design's counts
// Notes:   request line shows the old input level outside readouts
`timescale 1ns/100ps
module host_readout_model #(
    parameter int SAMPLE_WAIT = 20,
    parameter int HIGH_WAIT   = 10
) (
    input  wire logic clock,
    input  wire logic old_function_level,
    input  wire logic bit_data_out,
    input  wire logic takeover_active,
    output logic      position_read_enable,
    output logic      bit_request_strobe
);
    logic reading;
    logic req;
    initial begin
        position_read_enable = 1'b0;
        reading = 1'b0;
        req = 1'b1;
    end
    assign bit_request_strobe = reading ? req : old_function_level;
    task automatic read_frame(input int nbits, output logic [63:0] f);
        int w;
        f = '0;
        w = 0;
        position_read_enable <= 1'b1;
        reading <= 1'b1;
        req <= 1'b1;
        do begin
            @(posedge clock);
            w++;
        end while (!takeover_active && w < 300);
        for (int i = 0; i < nbits; i++) begin
            req <= 1'b0;
            repeat (SAMPLE_WAIT) @(posedge clock);
            f[i] = bit_data_out;
            req <= 1'b1;
            repeat (HIGH_WAIT) @(posedge clock);
        end
        position_read_enable <= 1'b0;
        repeat (6) @(posedge clock);
        reading <= 1'b0;
        // one idle edge, so a following call never rewrites reading in the same step
        @(posedge clock);
    endtask
endmodule

// >>> dv/tb_top.sv
// Purpose: self-checking bench of the position readout
// Assumes: shortened counts 20/5/50 cycles
// Notes:   check words in the table are worked out by hand
`timescale 1ns/100ps
module tb_top;
    import abs_readout_pkg::*;
    typedef struct packed {
        logic [15:0] turn;
        logic [31:0] pulse;
        logic [15:0] check;
    } row_t;
    row_t rows [4] = '{64'h04d2_00fffff0_5cc1, 64'hfb21_00fffff0_574e,
                       64'h8000_ffffffff_9360, 64'h0000_00000000_6160};
    logic clock, rst_n, enable, request, normal_out, old_level, sample_valid, battery_low, warn_sel;
    logic out_pin, held, takeover, sample_ready, fault, warning;
    position_sample_t sample_data;
    logic [63:0] frame;
    int errors, num_checks, cycles, n;

    abs_position_serial_readout #(.TAKEOVER_CYCLES(20), .PREPARE_CYCLES(5), .WARNING_CLEAR_CYCLES(50))
    u_abs_position_serial_readout (.clock(clock), .rst_n(rst_n), .position_read_enable(enable),
        .shared_input_terminal(request), .shared_output_terminal(out_pin), .normal_output_function(normal_out),
        .held_input_function(held), .takeover_active(takeover), .sample_data(sample_data),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .battery_low(battery_low),
        .battery_warning_select(warn_sel), .battery_fault(fault), .battery_warning(warning));
    host_readout_model u_host (.clock(clock), .old_function_level(old_level), .bit_data_out(out_pin),
        .takeover_active(takeover), .position_read_enable(enable), .bit_request_strobe(request));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) normal_out <= ~normal_out;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors = errors + 1;
            stop_test();
        end
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic push_one(input int r);
        sample_data <= rows[r][63:16];
        sample_valid <= 1'b1;
        @(posedge clock);
        sample_valid <= 1'b0;
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        {rst_n, sample_valid, battery_low, warn_sel, normal_out} = '0;
        sample_data = '0;
        old_level = 1'b1;
        {errors, num_checks, cycles} = '0;
        repeat (10) @(posedge clock);
        check({takeover, fault, warning, sample_ready, held, out_pin}, 6'b000100, "reset outputs");
        $display("test reset done");
        rst_n <= 1'b1;
        sample_valid <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            sample_data <= rows[i][63:16];
            @(posedge clock);
            while (!sample_ready) @(posedge clock);
        end
        sample_valid <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            u_host.read_frame(64, frame);
            check(frame[63:48], rows[i].check, "check word");
            check(frame, {rows[i].check, rows[i].turn, rows[i].pulse}, "frame");
            old_level <= 1'b0;
        end
        $display("test frames done");
        push_one(2);
        u_host.read_frame(10, frame);
        check(frame[9:0], 10'h3ff, "partial frame");
        check(takeover, 1'b0, "takeover after abort");
        push_one(1);
        u_host.read_frame(64, frame);
        check(frame, {rows[1].check, rows[1].turn, rows[1].pulse}, "frame after abort");
        $display("test abort done");
        sample_data <= rows[2][63:16];
        sample_valid <= 1'b1;
        n = 0;
        repeat (10) begin
            @(posedge clock);
            if (sample_ready) n++;
        end
        sample_valid <= 1'b0;
        check(n, 8, "words accepted");
        check(sample_ready, 1'b0, "full fifo ready");
        repeat (8) begin
            u_host.read_frame(2, frame);
            check(frame[1:0], 2'b11, "drained word");
        end
        check(sample_ready, 1'b1, "empty fifo ready");
        $display("test fifo done");
        battery_low <= 1'b1;
        repeat (5) @(posedge clock);
        check({fault, warning}, 2'b10, "fault mode");
        battery_low <= 1'b0;
        repeat (60) @(posedge clock);
        check(fault, 1'b1, "fault sticky");
        warn_sel <= 1'b1;
        battery_low <= 1'b1;
        repeat (5) @(posedge clock);
        check(warning, 1'b1, "warning raised");
        battery_low <= 1'b0;
        repeat (30) @(posedge clock);
        check(warning, 1'b1, "warning held");
        repeat (30) @(posedge clock);
        check(warning, 1'b0, "warning cleared");
        $display("test battery done");
        stop_test();
    end
endmodule

bind abs_position_serial_readout abs_readout_properties #(.TAKEOVER_CYCLES(TAKEOVER_CYCLES),
    .PREPARE_CYCLES(PREPARE_CYCLES), .WARNING_CLEAR_CYCLES(WARNING_CLEAR_CYCLES))
u_abs_readout_properties (.clock(clock), .rst_n(rst_n), .position_read_enable(position_read_enable),
    .shared_input_terminal(shared_input_terminal), .shared_output_terminal(shared_output_terminal),
    .normal_output_function(normal_output_function), .held_input_function(held_input_function),
    .takeover_active(takeover_active), .battery_low(battery_low), .battery_warning_select(battery_warning_select),
    .battery_fault(battery_fault), .battery_warning(battery_warning));
